// *** common/int_regs_params.svh ***
// register offsets, bit positions, reset values and fixed-bit masks of the interrupt enable and flag block
`ifndef INT_REGS_PARAMS_SVH
`define INT_REGS_PARAMS_SVH

// register bus geometry
`define REG_ADDR_W 3
`define REG_DATA_W 8

// register offsets
`define ADDR_PIN_EN 3'h0
`define ADDR_TMR_EN 3'h1
`define ADDR_PIN_FLG 3'h2
`define ADDR_EVT_STAT 3'h3
`define ADDR_EVT_MASK 3'h4

// bit positions in the enable and flag registers
`define BIT_DT 7
`define BIT_WAKE 5
`define BIT_P3 3
`define BIT_P0 0
`define BIT_TMR 5
`define BIT_SPARE 6

// storable bits and bits that always read as one
`define PIN_EN_WR_MASK 8'hA9
`define PIN_EN_ONES 8'h10
`define TMR_EN_WR_MASK 8'h60
`define TMR_EN_ONES 8'h1F
`define PIN_FLG_MASK 8'h89
`define PIN_FLG_ONES 8'h30

// event status bits
`define EVT_W 3
`define EVT_DT 2
`define EVT_P3 1
`define EVT_P0 0

// reset values
`define RST_BYTE 8'h00
`define RST_EVT 3'h0
`define PIN_IDLE 1'b1

`endif

// *** common/int_regs_pkg.sv ***
// types shared by the interrupt enable and flag block
`default_nettype none
package int_regs_pkg;
`include "int_regs_params.svh"

   // one register bus request
   typedef struct packed {
      logic [`REG_ADDR_W-1:0] addr;
      logic [`REG_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // gated requests toward the cpu interrupt controller
   typedef struct packed {
      logic direct_transition;
      logic wake_pin;
      logic ext_pin3;
      logic ext_pin0;
      logic timer_overflow;
   } int_req_t;

endpackage : int_regs_pkg
`default_nettype wire

// *** logic/interrupt_enable_flag_regs.sv ***
// interrupt enable and request flag registers with gated requests and an event interrupt
`timescale 1ns/1ps
`default_nettype none
`include "int_regs_params.svh"

// Function
// - Enable bit 7 of the pin register passes the direct transition request to the cpu and blocks it when clear.
// - Enable bit 5 of the pin register passes or blocks the wakeup pin request.
// - Enable bits 3 and 0 of the pin register pass or block the requests of external pins 3 and 0.
// - In the pin enable register bit 4 reads one, bits 6, 2 and 1 read zero, and writes to them do nothing.
// - Enable bit 5 of the timer register passes or blocks the timer overflow request.
// - Bit 6 of the timer register is a plain storage bit that software keeps at zero.
// - In the timer enable register bits 4 to 0 read one and bit 7 reads zero whatever is written.
// - A request arriving in the same cycle as a clear of its flag is still taken; a clear of its enable in that cycle blocks it, and only the flag keeps it.
// - The direct transition flag sets when a sleep makes a direct transfer while direct transfer is switched on.
// - The pin 3 flag sets when the pin is an interrupt input and its selected edge arrives.
// - The pin 0 flag sets when the pin is an interrupt input and its selected edge arrives.
// - A flag clears only by writing zero to it, writing one leaves it alone, and it is zero after reset.
// - An edge select of zero detects falling edges and one detects rising edges.
// - A flag that becomes one raises that source's request toward the cpu, subject to its enable.
module interrupt_enable_flag_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register bus
   input wire int_regs_pkg::bus_req_t bus,
   output logic [`REG_DATA_W-1:0] rdata,
   // external interrupt pins and their configuration
   input wire logic ext_int_pin_three,
   input wire logic ext_int_pin_zero,
   input wire logic ext_pin3_is_int,
   input wire logic ext_pin0_is_int,
   input wire logic ext_pin3_edge_sel,
   input wire logic ext_pin0_edge_sel,
   // direct transition source
   input wire logic sleep_direct_transfer,
   input wire logic direct_transfer_on,
   // flags kept in other blocks
   input wire logic wake_pin_flag,
   input wire logic timer_overflow_flag,
   // requests toward the cpu and the event interrupt
   output int_regs_pkg::int_req_t int_req,
   output logic irq
);
   import int_regs_pkg::*;

   logic [`REG_DATA_W-1:0] pin_and_transition_int_enable;
   logic [`REG_DATA_W-1:0] timer_int_enable;
   logic [`REG_DATA_W-1:0] pin_and_transition_int_flags;
   logic [`EVT_W-1:0] evt_status;
   logic [`EVT_W-1:0] evt_mask;
   logic [`REG_DATA_W-1:0] next_flags;
   logic [`EVT_W-1:0] next_status;
   logic ext_pin3_edge;
   logic ext_pin0_edge;

   // address decode
   wire sel_pin_en = (bus.addr == `ADDR_PIN_EN);
   wire sel_tmr_en = (bus.addr == `ADDR_TMR_EN);
   wire sel_pin_flg = (bus.addr == `ADDR_PIN_FLG);
   wire sel_stat = (bus.addr == `ADDR_EVT_STAT);
   wire sel_mask = (bus.addr == `ADDR_EVT_MASK);
   wire wr_pin_en = bus.wr & sel_pin_en;
   wire wr_tmr_en = bus.wr & sel_tmr_en;
   wire wr_pin_flg = bus.wr & sel_pin_flg;
   wire wr_stat = bus.wr & sel_stat;
   wire wr_mask = bus.wr & sel_mask;

   // named enable and flag bits
   wire direct_transition_int_en = pin_and_transition_int_enable[`BIT_DT];
   wire wake_pin_int_en = pin_and_transition_int_enable[`BIT_WAKE];
   wire ext_pin3_int_en = pin_and_transition_int_enable[`BIT_P3];
   wire ext_pin0_int_en = pin_and_transition_int_enable[`BIT_P0];
   wire timer_overflow_int_en = timer_int_enable[`BIT_TMR];
   wire direct_transition_req_flag = pin_and_transition_int_flags[`BIT_DT];
   wire ext_pin3_req_flag = pin_and_transition_int_flags[`BIT_P3];
   wire ext_pin0_req_flag = pin_and_transition_int_flags[`BIT_P0];

   // edge detectors for the two external pins
   pin_edge_watch u_pin3_edge (
      .clk(clk),
      .rst_n(rst_n),
      .pin(ext_int_pin_three),
      .pin_is_int(ext_pin3_is_int),
      .edge_sel(ext_pin3_edge_sel),
      .edge_pulse(ext_pin3_edge)
   );

   pin_edge_watch u_pin0_edge (
      .clk(clk),
      .rst_n(rst_n),
      .pin(ext_int_pin_zero),
      .pin_is_int(ext_pin0_is_int),
      .edge_sel(ext_pin0_edge_sel),
      .edge_pulse(ext_pin0_edge)
   );

   // flag set sources
   wire dt_set = sleep_direct_transfer & direct_transfer_on;
   wire [`REG_DATA_W-1:0] flag_set_vec = {dt_set, 3'h0, ext_pin3_edge, 2'h0, ext_pin0_edge};

   // a written zero clears a flag; ones and reserved bits change nothing
   wire [`REG_DATA_W-1:0] flag_clr_vec = wr_pin_flg ? (~bus.wdata & `PIN_FLG_MASK) : `RST_BYTE;

   // set wins over a clear in the same cycle so no request is lost
   always_comb begin
      next_flags = ((pin_and_transition_int_flags & ~flag_clr_vec) | flag_set_vec) & `PIN_FLG_MASK;
   end

   // enable registers keep only their storable bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_and_transition_int_enable <= `RST_BYTE;
         timer_int_enable <= `RST_BYTE;
      end else begin
         if (wr_pin_en) begin
            pin_and_transition_int_enable <= bus.wdata & `PIN_EN_WR_MASK;
         end
         if (wr_tmr_en) begin
            timer_int_enable <= bus.wdata & `TMR_EN_WR_MASK;
         end
      end
   end

   // request flags, zero after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_and_transition_int_flags <= `RST_BYTE;
      end else begin
         pin_and_transition_int_flags <= next_flags;
      end
   end

   // gated requests; a disabled flag still holds its event for later
   assign int_req.direct_transition = direct_transition_req_flag & direct_transition_int_en;
   assign int_req.wake_pin = wake_pin_flag & wake_pin_int_en;
   assign int_req.ext_pin3 = ext_pin3_req_flag & ext_pin3_int_en;
   assign int_req.ext_pin0 = ext_pin0_req_flag & ext_pin0_int_en;
   assign int_req.timer_overflow = timer_overflow_flag & timer_overflow_int_en;

   // event status: sticky, cleared by writing one, new event wins
   wire [`EVT_W-1:0] evt_set = {dt_set, ext_pin3_edge, ext_pin0_edge};
   wire [`EVT_W-1:0] evt_clr = wr_stat ? bus.wdata[`EVT_W-1:0] : `RST_EVT;

   always_comb begin
      next_status = (evt_status & ~evt_clr) | evt_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_status <= `RST_EVT;
         evt_mask <= `RST_EVT;
      end else begin
         evt_status <= next_status;
         if (wr_mask) begin
            evt_mask <= bus.wdata[`EVT_W-1:0];
         end
      end
   end

   // level interrupt while any unmasked event is pending
   assign irq = |(evt_status & evt_mask);

   // read selection; fixed bits come from constants, unmapped reads give zero
   wire [`REG_DATA_W-1:0] rd_pin_en = pin_and_transition_int_enable | `PIN_EN_ONES;
   wire [`REG_DATA_W-1:0] rd_tmr_en = timer_int_enable | `TMR_EN_ONES;
   wire [`REG_DATA_W-1:0] rd_pin_flg = pin_and_transition_int_flags | `PIN_FLG_ONES;
   wire [`REG_DATA_W-1:0] rd_stat = {{(`REG_DATA_W-`EVT_W){1'b0}}, evt_status};
   wire [`REG_DATA_W-1:0] rd_mask = {{(`REG_DATA_W-`EVT_W){1'b0}}, evt_mask};
   wire [`REG_DATA_W-1:0] rd_mux = sel_pin_en ? rd_pin_en :
                                   sel_tmr_en ? rd_tmr_en :
                                   sel_pin_flg ? rd_pin_flg :
                                   sel_stat ? rd_stat :
                                   sel_mask ? rd_mask : `RST_BYTE;

   // read data stand for the one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `RST_BYTE;
      end else begin
         rdata <= bus.rd ? rd_mux : `RST_BYTE;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_pin_en;
      bus.rd && (bus.addr == `ADDR_PIN_EN);
   endsequence

   sequence s_rd_tmr_en;
      bus.rd && (bus.addr == `ADDR_TMR_EN);
   endsequence

   sequence s_wr_tmr_spare;
      bus.wr && (bus.addr == `ADDR_TMR_EN);
   endsequence

   sequence s_clear_dt_flag;
      bus.wr && (bus.addr == `ADDR_PIN_FLG) && !bus.wdata[`BIT_DT];
   endsequence

   chk_dt_gate_block: assert property (!direct_transition_int_en |-> !int_req.direct_transition)
      else $error("direct transition request passed while disabled");

   chk_wake_gate_and: assert property (int_req.wake_pin == (wake_pin_flag && wake_pin_int_en))
      else $error("wake pin request does not follow flag and enable");

   chk_pin_gate_and: assert property ((int_req.ext_pin3 == (ext_pin3_req_flag && ext_pin3_int_en))
      && (int_req.ext_pin0 == (ext_pin0_req_flag && ext_pin0_int_en)))
      else $error("pin request does not follow flag and enable");

   chk_pin_en_fixed: assert property (s_rd_pin_en |=> rdata[4] && !rdata[6] && !rdata[2] && !rdata[1])
      else $error("pin enable fixed bits read wrong");

   chk_timer_gate_and: assert property (int_req.timer_overflow == (timer_overflow_flag && timer_overflow_int_en))
      else $error("timer request does not follow flag and enable");

   chk_spare_bit_store: assert property (s_wr_tmr_spare |=>
      timer_int_enable[`BIT_SPARE] == $past(bus.wdata[`BIT_SPARE]))
      else $error("spare timer bit not stored");

   chk_tmr_en_fixed: assert property (s_rd_tmr_en |=> (rdata[4:0] == 5'h1F) && !rdata[7])
      else $error("timer enable fixed bits read wrong");

   chk_set_beats_clear: assert property (s_clear_dt_flag ##0 dt_set |=> direct_transition_req_flag)
      else $error("direct transition event lost to a clear");

   chk_pin0_set_wins: assert property (wr_pin_flg && !bus.wdata[`BIT_P0] && ext_pin0_edge |=> ext_pin0_req_flag)
      else $error("pin 0 event lost to a clear");

   chk_dt_flag_set: assert property (sleep_direct_transfer && direct_transfer_on |=> direct_transition_req_flag)
      else $error("direct transition flag not set");

   chk_pin3_flag_set: assert property (ext_pin3_edge |=> ext_pin3_req_flag)
      else $error("pin 3 flag not set on edge");

   chk_pin0_flag_set: assert property (ext_pin0_edge |=> ext_pin0_req_flag)
      else $error("pin 0 flag not set on edge");

   chk_flag_hold_one: assert property (ext_pin3_req_flag && bus.wr && (bus.addr == `ADDR_PIN_FLG)
      && bus.wdata[`BIT_P3] |=> ext_pin3_req_flag)
      else $error("writing one changed a set flag");

   chk_flag_only_clear: assert property ($fell(ext_pin0_req_flag) |-> $past(wr_pin_flg) && !$past(bus.wdata[`BIT_P0]))
      else $error("pin 0 flag cleared without a zero write");

   chk_rise_raises_req: assert property ($rose(ext_pin3_req_flag) && ext_pin3_int_en |-> int_req.ext_pin3)
      else $error("new pin 3 flag did not raise its request");

   chk_disabled_records: assert property (ext_pin0_edge && !ext_pin0_int_en |=> ext_pin0_req_flag && !int_req.ext_pin0
      || ext_pin0_int_en)
      else $error("disabled pin 0 event not recorded");

   chk_irq_level: assert property (dt_set && evt_mask[`EVT_DT] && !wr_mask |=> irq)
      else $error("unmasked direct transition event did not raise the interrupt");

endmodule : interrupt_enable_flag_regs
`default_nettype wire

// *** logic/pin_edge_watch.sv ***
// edge detector for one external interrupt pin with selectable direction
`timescale 1ns/1ps
`default_nettype none
`include "int_regs_params.svh"
module pin_edge_watch (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin side
   input wire logic pin,
   input wire logic pin_is_int,
   input wire logic edge_sel,
   // detected edge
   output logic edge_pulse
);
   import int_regs_pkg::*;

   logic prev;

   // previous sample; idles high so a quiet pin gives no edge after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= `PIN_IDLE;
      end else begin
         prev <= pin;
      end
   end

   // select 0 watches falling edges, 1 watches rising edges
   wire rise = ~prev & pin;
   wire fall = prev & ~pin;
   assign edge_pulse = pin_is_int & (edge_sel ? rise : fall);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_edge_direction: assert property (edge_pulse |-> (edge_sel ? (pin && !prev) : (!pin && prev)))
      else $error("edge pulse does not match the selected direction");

endmodule : pin_edge_watch
`default_nettype wire

// *** testbench/cpu_int_model.sv ***
// behavioural cpu interrupt controller that latches gated requests while unmasked
`timescale 1ns/1ps
`default_nettype none
module cpu_int_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // requests from the block
   input wire int_regs_pkg::int_req_t int_req,
   input wire logic irq,
   // cpu state
   input wire logic cpu_mask,
   input wire logic cpu_ack,
   output int_regs_pkg::int_req_t taken
);
   import int_regs_pkg::*;

   // a request seen while unmasked stays taken until acknowledged, even if cleared the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         taken <= '0;
      end else if (cpu_ack) begin
         taken <= '0;
      end else if (!cpu_mask) begin
         taken <= taken | int_req;
      end
   end
endmodule : cpu_int_model
`default_nettype wire

// *** testbench/interrupt_enable_flag_regs_tb.sv ***
// self-checking testbench of the interrupt enable and flag registers
`timescale 1ns/1ps
`default_nettype none
`include "int_regs_params.svh"
module interrupt_enable_flag_regs_tb;
   import int_regs_pkg::*;
   logic clk, rst_n, sleep_dt, dt_on, wake_flg, tmr_flg, cpu_mask, cpu_ack, irq;
   logic [1:0] pin_lv, is_int, esel;
   logic [7:0] rdata;
   bus_req_t bus;
   int_req_t int_req, taken;
   int failures, check_count;

   interrupt_enable_flag_regs i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .ext_int_pin_three(pin_lv[1]), .ext_int_pin_zero(pin_lv[0]), .ext_pin3_is_int(is_int[1]),
      .ext_pin0_is_int(is_int[0]), .ext_pin3_edge_sel(esel[1]), .ext_pin0_edge_sel(esel[0]),
      .sleep_direct_transfer(sleep_dt), .direct_transfer_on(dt_on), .wake_pin_flag(wake_flg),
      .timer_overflow_flag(tmr_flg), .int_req(int_req), .irq(irq));
   cpu_int_model i_cpu (.clk(clk), .rst_n(rst_n), .int_req(int_req), .irq(irq),
      .cpu_mask(cpu_mask), .cpu_ack(cpu_ack), .taken(taken));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one-cycle write strobe, released at the next edge
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : reg_wr

   // read data are only valid in the cycle after the strobe
   task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask : reg_rd

   // move the pin to the inactive level first, then give the selected edge
   task automatic make_edge(input int p, input logic s);
      @(posedge clk);
      esel[p] <= s;
      pin_lv[p] <= ~s;
      repeat (2) @(posedge clk);
      pin_lv[p] <= s;
      repeat (2) @(posedge clk);
      #1;
   endtask : make_edge

   task automatic test_reset_values();
      logic [7:0] exp [6];
      exp = '{8'h10, 8'h1F, 8'h30, 8'h00, 8'h00, 8'h00};
      for (int a = 0; a < 6; a++) begin
         reg_rd(a[2:0], exp[a]);
      end
   endtask : test_reset_values

   // software keeps the spare timer bit at zero, so every other bit is written as one
   task automatic test_enable_bits();
      reg_wr(`ADDR_PIN_EN, 8'hFF);
      reg_rd(`ADDR_PIN_EN, 8'hB9);
      reg_wr(`ADDR_TMR_EN, 8'hBF);
      reg_rd(`ADDR_TMR_EN, 8'h3F);
      reg_wr(`ADDR_TMR_EN, 8'h00);
      reg_rd(`ADDR_TMR_EN, 8'h1F);
      reg_wr(`ADDR_PIN_EN, 8'h00);
      reg_rd(`ADDR_PIN_EN, 8'h10);
   endtask : test_enable_bits

   task automatic test_direct_transition();
      for (int on = 0; on < 2; on++) begin
         dt_on <= on[0];
         @(posedge clk);
         sleep_dt <= 1'b1;
         @(posedge clk);
         sleep_dt <= 1'b0;
         reg_rd(`ADDR_PIN_FLG, on ? 8'hB0 : 8'h30);
      end
      check({7'h00, int_req.direct_transition}, 8'h00);
      reg_wr(`ADDR_PIN_EN, 8'h80);
      #1 check({7'h00, int_req.direct_transition}, 8'h01);
      check({7'h00, irq}, 8'h00);
      reg_wr(`ADDR_EVT_MASK, 8'h04);
      #1 check({7'h00, irq}, 8'h01);
      reg_wr(`ADDR_EVT_STAT, 8'h04);
      #1 check({7'h00, irq}, 8'h00);
      cpu_mask <= 1'b1;
      reg_wr(`ADDR_PIN_FLG, 8'h00);
      reg_wr(`ADDR_PIN_EN, 8'h00);
      reg_rd(`ADDR_PIN_FLG, 8'h30);
   endtask : test_direct_transition

   task automatic test_pin_edges();
      logic [7:0] bitv;
      for (int p = 0; p < 2; p++) begin
         bitv = p ? 8'h08 : 8'h01;
         is_int[p] <= 1'b0;
         make_edge(p, 1'b0);
         pin_lv[p] <= 1'b1;
         is_int[p] <= 1'b1;
         reg_rd(`ADDR_PIN_FLG, 8'h30);
         for (int s = 0; s < 2; s++) begin
            make_edge(p, s[0]);
            pin_lv[p] <= 1'b1;
            reg_rd(`ADDR_PIN_FLG, 8'h30 | bitv);
            check(8'(p ? int_req.ext_pin3 : int_req.ext_pin0), 8'h00);
            reg_wr(`ADDR_PIN_EN, bitv);
            #1 check(8'(p ? int_req.ext_pin3 : int_req.ext_pin0), 8'h01);
            reg_wr(`ADDR_PIN_FLG, 8'hFF);
            reg_rd(`ADDR_PIN_FLG, 8'h30 | bitv);
            reg_wr(`ADDR_PIN_FLG, 8'h00);
            reg_rd(`ADDR_PIN_FLG, 8'h30);
            reg_wr(`ADDR_PIN_EN, 8'h00);
         end
      end
      reg_rd(`ADDR_EVT_STAT, 8'h03);
      reg_wr(`ADDR_EVT_STAT, 8'h07);
   endtask : test_pin_edges

   task automatic test_wake_timer();
      wake_flg <= 1'b1;
      tmr_flg <= 1'b1;
      @(posedge clk);
      #1 check({6'h00, int_req.wake_pin, int_req.timer_overflow}, 8'h00);
      reg_wr(`ADDR_PIN_EN, 8'h20);
      reg_wr(`ADDR_TMR_EN, 8'h20);
      #1 check({6'h00, int_req.wake_pin, int_req.timer_overflow}, 8'h03);
      wake_flg <= 1'b0;
      tmr_flg <= 1'b0;
      reg_wr(`ADDR_PIN_EN, 8'h00);
   endtask : test_wake_timer

   // a flag clear meets a new pin 0 rising edge and a direct transition at the same edge while unmasked
   task automatic test_clear_collision();
      cpu_ack <= 1'b1;
      reg_wr(`ADDR_PIN_EN, 8'h01);
      cpu_ack <= 1'b0;
      cpu_mask <= 1'b0;
      pin_lv[0] <= 1'b0;
      repeat (2) @(posedge clk);
      bus <= '{addr: `ADDR_PIN_FLG, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
      pin_lv[0] <= 1'b1;
      sleep_dt <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      sleep_dt <= 1'b0;
      reg_rd(`ADDR_PIN_FLG, 8'hB1);
      check(8'(taken.ext_pin0), 8'h01);
      check({7'h00, irq}, 8'h01);
   endtask : test_clear_collision

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // cut a hang short after far more cycles than the tests need
   initial begin
      #(40 * 5000);
      failures++;
      print_verdict();
   end

   initial begin
      failures = 0;
      check_count = 0;
      rst_n = 1'b0;
      bus = '0;
      pin_lv = 2'b11;
      is_int = 2'b11;
      esel = 2'b00;
      sleep_dt = 1'b0;
      dt_on = 1'b0;
      wake_flg = 1'b0;
      tmr_flg = 1'b0;
      cpu_mask = 1'b1;
      cpu_ack = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      test_reset_values();
      test_enable_bits();
      test_direct_transition();
      test_pin_edges();
      test_wake_timer();
      test_clear_collision();
      print_verdict();
   end
endmodule : interrupt_enable_flag_regs_tb
`default_nettype wire
